// [logic/wsp_slave_port.sv]
`timescale 1ns/1ps
`default_nettype none
module wsp_slave_port import wsp_pkg::*; (
  input wire logic mclk, // block clock, 10 mhz
  input wire logic rst, // async reset, active high
  input wire logic sck_pin, // serial clock from host
  input wire logic slave_select_n, // select from host, active low
  input wire logic mosi_pin, // serial data in
  input wire logic cfg_strap, // configuration strap pin
  input wire logic cpol, // clock polarity, static config
  input wire logic cpha, // clock phase, static config
  output logic miso_out, // serial data out
  output logic miso_oe_n, // miso enable, low while driving
  output logic port_ready, // strap captured high, port usable
  output logic wr_strobe, // one-cycle pulse per register write
  output logic [7:0] wr_addr, // address of that write
  output logic [7:0] wr_data, // data of that write
  output logic dma_start, // one-cycle pulse to start dma
  output logic [7:0] dma_arg // argument byte of the dma command
);
  wsp_pins_t pins_raw; // pins before the synchroniser
  wsp_pins_t pins_s; // pins after the synchroniser

  // every host pin is synchronised; the host clock is just sampled data
  assign pins_raw = '{sck: sck_pin, slave_select_n: slave_select_n, mosi: mosi_pin, strap: cfg_strap};
  wsp_sync u_sync (
    .mclk(mclk),
    .rst(rst),
    .pins_raw(pins_raw),
    .pins_sync(pins_s)
  );

  // state and its next values
  logic [1:0] cap_cnt_reg, cap_cnt_next; // strap wait counter
  logic port_en_reg, port_en_next; // strap captured high
  logic sck_prev_reg, sck_prev_next; // last synced clock level
  logic [2:0] bitcnt_reg, bitcnt_next; // bits sampled in this byte
  logic [7:0] rx_reg, rx_next; // receive shift register
  logic [7:0] tx_reg, tx_next; // transmit shift register, msb on miso
  logic [7:0] resp_reg, resp_next; // byte to send after this one
  logic [1:0] cmd_reg, cmd_next; // command of the current frame
  logic [7:0] addr_reg, addr_next; // address of the current frame
  wsp_phase_t phase_reg, phase_next; // position in the frame
  logic oe_n_reg, oe_n_next; // miso enable, low while driving
  logic wr_strobe_reg, wr_strobe_next;
  logic [7:0] wr_addr_reg, wr_addr_next;
  logic [7:0] wr_data_reg, wr_data_next;
  logic dma_reg, dma_next;
  logic [7:0] dma_arg_reg, dma_arg_next;
  logic [7:0] mem [WSP_REG_DEPTH]; // host-visible register file
  logic mem_we; // register file write enable
  logic [WSP_REG_AW-1:0] mem_wa; // register file write address
  logic [7:0] mem_wd; // register file write data

  // decoded events, shared by the next-state logic and the checks
  logic active; // selected and enabled
  logic sck_rise; // synced clock rose
  logic sck_fall; // synced clock fell
  logic lead_ev; // leading edge for the current polarity
  logic trail_ev; // trailing edge for the current polarity
  logic samp_ev; // sample mosi now
  logic shft_ev; // move to the next miso bit now
  logic [7:0] rx_byte; // byte including the bit sampled now

  // edge decode; a slow mclk versus sck is a limitation: sck must
  // stay under about a fifth of mclk or edges are missed
  always_comb begin
    active = port_en_reg && !pins_s.slave_select_n;
    sck_rise = pins_s.sck && !sck_prev_reg;
    sck_fall = !pins_s.sck && sck_prev_reg;
    lead_ev = cpol ? sck_fall : sck_rise;
    trail_ev = cpol ? sck_rise : sck_fall;
    samp_ev = active && (cpha ? trail_ev : lead_ev);
    shft_ev = active && (cpha ? lead_ev : trail_ev);
    rx_byte = {rx_reg[6:0], pins_s.mosi};
  end

  // next-state logic for the whole port
  always_comb begin
    cap_cnt_next = cap_cnt_reg;
    port_en_next = port_en_reg;
    sck_prev_next = pins_s.sck;
    bitcnt_next = bitcnt_reg;
    rx_next = rx_reg;
    tx_next = tx_reg;
    resp_next = resp_reg;
    cmd_next = cmd_reg;
    addr_next = addr_reg;
    phase_next = phase_reg;
    wr_strobe_next = 1'b0;
    wr_addr_next = wr_addr_reg;
    wr_data_next = wr_data_reg;
    dma_next = 1'b0;
    dma_arg_next = dma_arg_reg;
    mem_we = 1'b0;
    mem_wa = addr_reg[WSP_REG_AW-1:0];
    mem_wd = rx_byte;
    // catch the strap once the synchroniser holds its settled value
    if (cap_cnt_reg != WSP_STRAP_WAIT) begin
      cap_cnt_next = cap_cnt_reg + 2'h1;
      if (cap_cnt_reg == WSP_STRAP_WAIT - 2'h1) begin
        port_en_next = pins_s.strap;
      end
    end
    oe_n_next = !active;
    if (!active) begin
      // deselected: frame state parked, bus activity ignored
      bitcnt_next = 3'h0;
      phase_next = PH_CMD;
      tx_next = WSP_IDLE_BYTE;
      resp_next = WSP_IDLE_BYTE;
    end else begin
      // shift and sample happen on opposite edges, never together
      if (shft_ev) begin
        // at a byte boundary load the prepared answer instead of shifting
        tx_next = (bitcnt_reg == 3'h0) ? resp_reg : {tx_reg[6:0], 1'b0};
      end
      if (samp_ev) begin
        rx_next = rx_byte;
        bitcnt_next = bitcnt_reg + 3'h1;
        if (bitcnt_reg == WSP_LAST_BIT) begin
          resp_next = WSP_IDLE_BYTE;
          case (phase_reg)
            PH_CMD: begin
              cmd_next = rx_byte[WSP_CMD_MSB:WSP_CMD_LSB];
              phase_next = PH_ADDR;
            end
            PH_ADDR: begin
              addr_next = rx_byte;
              if (cmd_reg == WSP_CMD_DMA) begin
                dma_next = 1'b1;
                dma_arg_next = rx_byte;
                phase_next = PH_HOLD;
              end else begin
                phase_next = PH_DATA;
                if (cmd_reg == WSP_CMD_READ) begin
                  resp_next = mem[rx_byte[WSP_REG_AW-1:0]];
                end
              end
            end
            PH_DATA: begin
              // reserved command code 3 is a silent no-op
              if (cmd_reg == WSP_CMD_WRITE) begin
                mem_we = 1'b1;
                wr_strobe_next = 1'b1;
                wr_addr_next = addr_reg;
                wr_data_next = rx_byte;
              end
              phase_next = PH_HOLD;
            end
            default: begin
              phase_next = PH_HOLD; // extra bytes are clocked and dropped
            end
          endcase
        end
      end
    end
  end

  // registers of the port
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      cap_cnt_reg <= 2'h0;
      port_en_reg <= 1'b0;
      sck_prev_reg <= 1'b0;
      bitcnt_reg <= 3'h0;
      rx_reg <= 8'h00;
      tx_reg <= WSP_IDLE_BYTE;
      resp_reg <= WSP_IDLE_BYTE;
      cmd_reg <= WSP_CMD_READ;
      addr_reg <= 8'h00;
      phase_reg <= PH_CMD;
      oe_n_reg <= 1'b1;
      wr_strobe_reg <= 1'b0;
      wr_addr_reg <= 8'h00;
      wr_data_reg <= 8'h00;
      dma_reg <= 1'b0;
      dma_arg_reg <= 8'h00;
    end else begin
      cap_cnt_reg <= cap_cnt_next;
      port_en_reg <= port_en_next;
      sck_prev_reg <= sck_prev_next;
      bitcnt_reg <= bitcnt_next;
      rx_reg <= rx_next;
      tx_reg <= tx_next;
      resp_reg <= resp_next;
      cmd_reg <= cmd_next;
      addr_reg <= addr_next;
      phase_reg <= phase_next;
      oe_n_reg <= oe_n_next;
      wr_strobe_reg <= wr_strobe_next;
      wr_addr_reg <= wr_addr_next;
      wr_data_reg <= wr_data_next;
      dma_reg <= dma_next;
      dma_arg_reg <= dma_arg_next;
    end
  end

  // register file; only the low address bits decode, so it mirrors
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < WSP_REG_DEPTH; i++) begin
        mem[i] <= WSP_REG_RST;
      end
    end else if (mem_we) begin
      mem[mem_wa] <= mem_wd;
    end
  end

  // outputs straight from flops
  assign miso_out = tx_reg[7];
  assign miso_oe_n = oe_n_reg;
  assign port_ready = port_en_reg;
  assign wr_strobe = wr_strobe_reg;
  assign wr_addr = wr_addr_reg;
  assign wr_data = wr_data_reg;
  assign dma_start = dma_reg;
  assign dma_arg = dma_arg_reg;

  // checks
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);

  chk_miso_tristate: assert property (pins_s.slave_select_n |=> miso_oe_n)
    else $error("miso driven while deselected");
  chk_strap_gate: assert property (!port_en_reg |=> miso_oe_n && !wr_strobe_reg)
    else $error("port acted without strap");
  chk_deselect_idle: assert property (pins_s.slave_select_n ##1 pins_s.slave_select_n |-> bitcnt_reg == 3'h0)
    else $error("bit count moved while deselected");
  chk_sample_count: assert property (samp_ev |=> bitcnt_reg == $past(bitcnt_reg) + 3'h1)
    else $error("sample did not advance bit count");
  chk_mosi_capture: assert property (samp_ev |=> rx_reg[0] == $past(pins_s.mosi))
    else $error("mosi bit not captured");
  chk_cpha0_lead: assert property (active && !cpha && lead_ev |=> rx_reg[0] == $past(pins_s.mosi))
    else $error("cpha 0 must sample on leading edge");
  chk_write_mem: assert property (wr_strobe_reg |-> mem[wr_addr_reg[WSP_REG_AW-1:0]] == wr_data_reg)
    else $error("write strobe without stored data");
  chk_pulse_width: assert property (wr_strobe_reg || dma_reg |=> !wr_strobe_reg && !dma_reg)
    else $error("pulse longer than one cycle");
  chk_drive_on_select: assert property (active |=> !miso_oe_n)
    else $error("miso not driven while selected");

  cov_write_mode0: cover property (!cpol && !cpha && wr_strobe_reg);
  cov_write_mode3: cover property (cpol && cpha && wr_strobe_reg);
  cov_dma_start: cover property (dma_reg);
  cov_read_answer: cover property (phase_reg == PH_DATA && cmd_reg == WSP_CMD_READ && shft_ev);
endmodule
`default_nettype wire

// [logic/wsp_pkg.sv]
`default_nettype none
package wsp_pkg;
  // command codes carried in the top two bits of the first byte
  localparam logic [1:0] WSP_CMD_READ = 2'h0; // read one internal register
  localparam logic [1:0] WSP_CMD_WRITE = 2'h1; // write one internal register
  localparam logic [1:0] WSP_CMD_DMA = 2'h2; // start a dma transfer
  localparam int WSP_CMD_MSB = 7; // command field position
  localparam int WSP_CMD_LSB = 6;
  // internal register file
  localparam int WSP_REG_DEPTH = 16; // registers reachable from the host
  localparam int WSP_REG_AW = 4; // address bits actually decoded
  localparam logic [7:0] WSP_IDLE_BYTE = 8'h00; // sent when nothing to answer
  localparam logic [7:0] WSP_REG_RST = 8'h00; // register reset value
  // strap capture: wait for the synchroniser to fill before sampling
  localparam logic [1:0] WSP_STRAP_WAIT = 2'h3;
  localparam logic [2:0] WSP_LAST_BIT = 3'h7; // index of the eighth bit
  // pins from the host, gathered for the synchroniser
  typedef struct packed {
    logic sck; // serial clock
    logic slave_select_n; // slave select, active low
    logic mosi; // host to slave data
    logic strap; // configuration strap
  } wsp_pins_t;
  localparam wsp_pins_t WSP_PINS_RST = '{sck: 1'b0, slave_select_n: 1'b1, mosi: 1'b0, strap: 1'b0};
  // protocol phase inside one select window
  typedef enum logic [1:0] {PH_CMD, PH_ADDR, PH_DATA, PH_HOLD} wsp_phase_t;
endpackage
`default_nettype wire

// [logic/wsp_sync.sv]
`timescale 1ns/1ps
`default_nettype none
// two-stage synchroniser for every pin that arrives from the host
module wsp_sync import wsp_pkg::*; (
  input wire logic mclk, // block clock
  input wire logic rst, // async reset, active high
  input wire wsp_pins_t pins_raw, // pins straight from the pads
  output var wsp_pins_t pins_sync // pins after two flops
);
  wsp_pins_t meta_reg; // first stage, read only by the second
  wsp_pins_t sync_reg; // second stage
  // reset to deselected so no frame is seen while reset holds
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      meta_reg <= WSP_PINS_RST;
      sync_reg <= WSP_PINS_RST;
    end else begin
      meta_reg <= pins_raw;
      sync_reg <= meta_reg;
    end
  end
  assign pins_sync = sync_reg;
endmodule
`default_nettype wire

// [tb/wsp_host_model.sv]
`timescale 1ns/1ps
`default_nettype none
// serial master on the far side: makes the clock, select and mosi
module wsp_host_model (
  input wire logic mclk, // bench clock, host steps on its falling edge
  input wire logic cpol, // idle level of sck
  input wire logic cpha, // clock phase of the bus
  input wire logic miso_out, // slave data
  input wire logic miso_oe_n, // slave enable, low while driving
  output logic sck, // serial clock, still outside frames
  output logic slave_select_n, // slave select, active low
  output logic mosi // host to slave data
);
  logic [23:0] rxw; // bits seen on miso in the last frame
  logic miso_last; // last level the slave drove
  logic miso_w; // wire level seen by the host
  initial begin
    sck = 1'b0;
    slave_select_n = 1'b1;
    mosi = 1'b0;
    miso_last = 1'b0;
    rxw = 24'h0;
  end
  // no pull on the line, so a released miso shows the inverse of its last level
  // looked at mid-cycle, where the slave's flops have settled
  always @(negedge mclk) begin
    if (miso_oe_n == 1'b0) miso_last <= miso_out;
  end
  assign miso_w = miso_oe_n ? ~miso_last : miso_out;
  // one frame of three bytes, msb first; sel low keeps this slave deselected
  task automatic frame(input logic [23:0] tx, input logic sel);
    int i;
    sck = cpol;
    repeat (6) @(negedge mclk);
    slave_select_n = ~sel;
    mosi = tx[23];
    repeat (6) @(negedge mclk);
    for (i = 23; i >= 0; i--) begin
      if (!cpha) rxw[i] = miso_w;
      sck = ~cpol;
      if (cpha) mosi = tx[i];
      repeat (4) @(negedge mclk);
      if (cpha) rxw[i] = miso_w;
      sck = cpol;
      if (!cpha && i > 0) mosi = tx[i-1];
      repeat (4) @(negedge mclk);
    end
    repeat (2) @(negedge mclk);
    slave_select_n = 1'b1;
    mosi = ~mosi; // released line, value no longer held
    repeat (6) @(negedge mclk);
  endtask
endmodule
`default_nettype wire

// [tb/wsp_slave_port_tb.sv]
`timescale 1ns/1ps
`default_nettype none
// bench for the serial slave port, host model drives the bus
module wsp_slave_port_tb;
  logic mclk; // block clock, 100 ns
  logic rst; // async reset, active high
  logic cfg_strap; // configuration strap
  logic cpol; // clock polarity
  logic cpha; // clock phase
  logic sck; // serial clock from host
  logic slave_select_n; // select from host, active low
  logic mosi; // host data
  logic miso_out; // slave data
  logic miso_oe_n; // slave enable, low while driving
  logic port_ready; // port usable
  logic wr_strobe; // register write pulse
  logic [7:0] wr_addr; // write address
  logic [7:0] wr_data; // write data
  logic dma_start; // dma pulse
  logic [7:0] dma_arg; // dma argument
  int err_count = 0; // mismatches
  int tests_run = 0; // comparisons
  int wr_cnt = 0; // write pulses seen
  int dma_cnt = 0; // dma pulses seen
  int oe_low = 0; // cycles with miso driven
  initial begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end
  wsp_slave_port dut (.mclk(mclk), .rst(rst), .sck_pin(sck), .slave_select_n(slave_select_n),
    .mosi_pin(mosi), .cfg_strap(cfg_strap), .cpol(cpol), .cpha(cpha), .miso_out(miso_out),
    .miso_oe_n(miso_oe_n), .port_ready(port_ready), .wr_strobe(wr_strobe), .wr_addr(wr_addr),
    .wr_data(wr_data), .dma_start(dma_start), .dma_arg(dma_arg));
  wsp_host_model host (.mclk(mclk), .cpol(cpol), .cpha(cpha), .miso_out(miso_out),
    .miso_oe_n(miso_oe_n), .sck(sck), .slave_select_n(slave_select_n), .mosi(mosi));
  // pulses last one cycle, so they are counted here rather than polled;
  // counted mid-cycle so the edge that launches them cannot race the read
  always @(negedge mclk) begin
    if (wr_strobe === 1'b1) wr_cnt++;
    if (dma_start === 1'b1) dma_cnt++;
    if (miso_oe_n === 1'b0) oe_low++;
  end
  task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp) begin
      err_count++;
      $display("wrong value at %0t: byte %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk_bit(input logic got, input logic exp);
    tests_run++;
    if (got !== exp) begin
      err_count++;
      $display("wrong value at %0t: bit %b expected %b", $time, got, exp);
    end
  endtask
  // strap is only caught after release, so it is set during reset
  task automatic do_reset(input logic strap);
    cfg_strap = strap;
    rst = 1'b1;
    repeat (5) @(negedge mclk);
    chk_bit(port_ready, 1'b0);
    chk_bit(miso_oe_n, 1'b1);
    rst = 1'b0;
    repeat (10) @(negedge mclk);
    chk_bit(port_ready, strap);
  endtask
  // strap low: a whole write frame must leave no trace
  task automatic t_strap_low();
    int w0;
    int o0;
    do_reset(1'b0);
    w0 = wr_cnt;
    o0 = oe_low;
    host.frame({wsp_pkg::WSP_CMD_WRITE, 6'h00, 8'h01, 8'h5A}, 1'b1);
    chk_byte(8'(wr_cnt - w0), 8'h00);
    chk_byte(8'(oe_low - o0), 8'h00);
    do_reset(1'b1);
    $display("test strap low done");
  endtask
  // every mode: write, then read back through a mirrored address
  task automatic t_modes();
    int m;
    int w0;
    logic [7:0] d;
    for (m = 0; m < 4; m++) begin
      cpol = m[1];
      cpha = m[0];
      d = 8'h96 + 8'(m);
      w0 = wr_cnt;
      host.frame({wsp_pkg::WSP_CMD_WRITE, 6'h15, 8'h03 + 8'(m), d}, 1'b1);
      chk_byte(8'(wr_cnt - w0), 8'h01);
      chk_byte(wr_addr, 8'h03 + 8'(m));
      chk_byte(wr_data, d);
      chk_bit(miso_oe_n, 1'b1);
      host.frame({wsp_pkg::WSP_CMD_READ, 6'h2A, 8'hF3 + 8'(m), 8'h00}, 1'b1);
      chk_byte(host.rxw[7:0], d);
      chk_byte(8'(wr_cnt - w0), 8'h01);
    end
    $display("test modes done");
  endtask
  // dma start carries its argument; the spare code does nothing
  task automatic t_dma();
    int w0;
    int d0;
    w0 = wr_cnt;
    d0 = dma_cnt;
    host.frame({wsp_pkg::WSP_CMD_DMA, 6'h3F, 8'hC3, 8'h00}, 1'b1);
    chk_byte(8'(dma_cnt - d0), 8'h01);
    chk_byte(dma_arg, 8'hC3);
    host.frame({2'h3, 6'h00, 8'h44, 8'h55}, 1'b1);
    chk_byte(8'(dma_cnt - d0), 8'h01);
    chk_byte(8'(wr_cnt - w0), 8'h00);
    $display("test dma done");
  endtask
  // traffic for another slave while this one is deselected
  task automatic t_desel();
    int w0;
    int o0;
    w0 = wr_cnt;
    o0 = oe_low;
    host.frame({wsp_pkg::WSP_CMD_WRITE, 6'h00, 8'h07, 8'hE1}, 1'b0);
    chk_byte(8'(wr_cnt - w0), 8'h00);
    chk_byte(8'(oe_low - o0), 8'h00);
    chk_byte(wr_data, 8'h99);
    $display("test deselect done");
  endtask
  task automatic results();
    $display("comparisons %0d mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  initial begin
    rst = 1'b1;
    cfg_strap = 1'b1;
    cpol = 1'b0;
    cpha = 1'b0;
    @(negedge mclk);
    do_reset(1'b1);
    $display("test reset done");
    t_strap_low();
    t_modes();
    t_dma();
    t_desel();
    results();
  end
endmodule
`default_nettype wire
